// ---- lpbps_snapshot.sv ----
// Purpose: read-only snapshot of the partner base page bits 47:16, read over APB
// Assumes: PARTNER_PAGE is the live received base page, synchronous to REF_CLK
// Notes:   one wait state on every transfer so read data comes from a flop
//
// Operation
// - low word read freezes mid and high words
// - mid and high reads return the frozen snapshot
// - mid bit 14 shows partner long reach ability
// - mid bit 7 shows partner gigabit ability
// - mid bit 6 shows partner short reach full duplex
// - mid bit 5 shows partner fast ability
// - mid bit 4 shows partner master select
// - high bit 14 shows partner energy efficient ability
// - high bit 13 shows partner high amplitude ability
// - high bit 11 shows partner short reach half duplex
// - both words reset to zero, reserved read zero
// - transmit level high only if both able, one requests
`timescale 1ns/1ps
`include "lpbps_params.svh"

module lpbps_snapshot #(
   parameter int ADDR_W = 14
) (
   input  wire logic              REF_CLK,
   input  wire logic              RST,
   input  wire logic              PSEL,
   input  wire logic              PENABLE,
   input  wire logic              PWRITE,
   input  wire logic [ADDR_W-1:0] PADDR,
   input  wire logic [31:0]       PWDATA,
   output logic                   PREADY,
   output logic [31:0]            PRDATA,
   output logic                   PSLVERR,
   input  wire logic [47:0]       PARTNER_PAGE,
   input  wire logic              LOCAL_HIGH_AMPLITUDE_ABLE,
   input  wire logic              LOCAL_HIGH_AMPLITUDE_REQUEST,
   output logic                   TX_LEVEL_HIGH
);

   // the highest index times four must fit the address; refused at elaboration
   if (ADDR_W < 12) begin : g_addr_check
      $error("lpbps_snapshot: ADDR_W must be at least 12");
   end

   // map a byte address to the register it selects; low two bits must be zero
   function automatic lpbps_pkg::lpbps_sel_e decode(input logic [ADDR_W-1:0] addr);
      logic [ADDR_W-1:0] idx;
      idx = addr >> 2;
      if (addr[1:0] != 2'h0) begin
         decode = lpbps_pkg::LPBPS_SEL_NONE;
      end else if (idx == ADDR_W'(`LPBPS_IDX_LOW_WORD)) begin
         decode = lpbps_pkg::LPBPS_SEL_LOW;
      end else if (idx == ADDR_W'(`LPBPS_IDX_MID_WORD)) begin
         decode = lpbps_pkg::LPBPS_SEL_MID;
      end else if (idx == ADDR_W'(`LPBPS_IDX_HIGH_WORD)) begin
         decode = lpbps_pkg::LPBPS_SEL_HIGH;
      end else begin
         decode = lpbps_pkg::LPBPS_SEL_NONE;
      end
   endfunction : decode

   lpbps_pkg::lpbps_sel_e  sel;
   lpbps_pkg::lpbps_snap_s snap;
   logic [15:0]            live_mid;
   logic [15:0]            live_high;
   logic                   access;
   logic                   low_read_done;
   logic                   write_done;
   logic                   next_tx_high;

   // reserved positions are masked so they can never read as one
   assign live_mid      = PARTNER_PAGE[31:16] & `LPBPS_MID_MASK;
   assign live_high     = PARTNER_PAGE[47:32] & `LPBPS_HIGH_MASK;
   assign sel           = decode(PADDR);
   assign access        = PSEL & PENABLE & ~PREADY;
   assign low_read_done = PSEL & PENABLE & PREADY & ~PWRITE & (sel == lpbps_pkg::LPBPS_SEL_LOW);
   assign write_done    = PSEL & PENABLE & PREADY & PWRITE;

   // one wait state: ready rises in the second access cycle
   always_ff @(posedge REF_CLK) begin
      if (RST) begin
         PREADY <= 1'b0;
      end else begin
         PREADY <= access;
      end
   end

   // read data and error loaded in the first access cycle, held through ready
   always_ff @(posedge REF_CLK) begin
      if (RST) begin
         PRDATA  <= 32'h00000000;
         PSLVERR <= 1'b0;
      end else if (access) begin
         PSLVERR <= (sel == lpbps_pkg::LPBPS_SEL_NONE);
         case (sel)
            lpbps_pkg::LPBPS_SEL_LOW:  PRDATA <= {16'h0000, PARTNER_PAGE[15:0]};
            lpbps_pkg::LPBPS_SEL_MID:  PRDATA <= {16'h0000, snap.mid};
            lpbps_pkg::LPBPS_SEL_HIGH: PRDATA <= {16'h0000, snap.high};
            default:                   PRDATA <= 32'h00000000;
         endcase
      end else if (!PSEL) begin
         PSLVERR <= 1'b0;
      end
   end

   // freeze only on a completed low word read; writes never reach here
   always_ff @(posedge REF_CLK) begin
      if (RST) begin
         snap.mid  <= `LPBPS_WORD_RESET;
         snap.high <= `LPBPS_WORD_RESET;
      end else if (low_read_done) begin
         snap.mid  <= live_mid;
         snap.high <= live_high;
      end
   end

   // level resolution follows the live page so the link need not wait for software
   assign next_tx_high = LOCAL_HIGH_AMPLITUDE_ABLE & PARTNER_PAGE[32+`LPBPS_HIGH_HI_ABLE]
                       & (LOCAL_HIGH_AMPLITUDE_REQUEST | PARTNER_PAGE[32+`LPBPS_HIGH_HI_REQ]);

   always_ff @(posedge REF_CLK) begin
      if (RST) begin
         TX_LEVEL_HIGH <= 1'b0;
      end else begin
         TX_LEVEL_HIGH <= next_tx_high;
      end
   end

   // completed read of the low word
   sequence s_low_read;
      low_read_done;
   endsequence

   // an access phase answered after exactly one wait cycle
   sequence s_access_wait;
      PSEL && PENABLE && !PREADY ##1 PREADY;
   endsequence

   property p_capture;
      @(posedge REF_CLK) disable iff (RST)
      s_low_read |=> (snap.mid == $past(live_mid)) && (snap.high == $past(live_high));
   endproperty
   a_capture: assert property (p_capture) else $error("snapshot not taken on low read");

   property p_hold;
      @(posedge REF_CLK) disable iff (RST)
      !low_read_done |=> $stable(snap);
   endproperty
   a_hold: assert property (p_hold) else $error("snapshot moved without low read");

   property p_mid_read;
      @(posedge REF_CLK) disable iff (RST)
      (PREADY && !PWRITE && sel == lpbps_pkg::LPBPS_SEL_MID) |-> PRDATA == {16'h0000, snap.mid};
   endproperty
   a_mid_read: assert property (p_mid_read) else $error("mid read not the snapshot");

   property p_mid_fields;
      @(posedge REF_CLK) disable iff (RST)
      s_low_read |=> snap.mid[14] == $past(PARTNER_PAGE[30]) && snap.mid[7] == $past(PARTNER_PAGE[23])
                  && snap.mid[6] == $past(PARTNER_PAGE[22]) && snap.mid[5] == $past(PARTNER_PAGE[21])
                  && snap.mid[4] == $past(PARTNER_PAGE[20]);
   endproperty
   a_mid_fields: assert property (p_mid_fields) else $error("mid field misplaced");

   property p_high_fields;
      @(posedge REF_CLK) disable iff (RST)
      s_low_read |=> snap.high[14] == $past(PARTNER_PAGE[46]) && snap.high[13] == $past(PARTNER_PAGE[45])
                  && snap.high[11] == $past(PARTNER_PAGE[43]);
   endproperty
   a_high_fields: assert property (p_high_fields) else $error("high field misplaced");

   property p_reserved_zero;
      @(posedge REF_CLK) disable iff (RST)
      ((snap.mid & ~`LPBPS_MID_MASK) == 16'h0000) && ((snap.high & ~`LPBPS_HIGH_MASK) == 16'h0000);
   endproperty
   a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bit set");

   property p_reset_zero;
      @(posedge REF_CLK)
      RST |=> snap.mid == 16'h0000 && snap.high == 16'h0000;
   endproperty
   a_reset_zero: assert property (p_reset_zero) else $error("snapshot not cleared by reset");

   property p_level;
      @(posedge REF_CLK) disable iff (RST)
      ##1 TX_LEVEL_HIGH == ($past(LOCAL_HIGH_AMPLITUDE_ABLE) && $past(PARTNER_PAGE[45])
                         && ($past(LOCAL_HIGH_AMPLITUDE_REQUEST) || $past(PARTNER_PAGE[44])));
   endproperty
   a_level: assert property (p_level) else $error("transmit level misresolved");

   property p_write_ignored;
      @(posedge REF_CLK) disable iff (RST)
      write_done |=> $stable(snap);
   endproperty
   a_write_ignored: assert property (p_write_ignored) else $error("write changed snapshot");

   property p_one_wait;
      @(posedge REF_CLK) disable iff (RST)
      (PSEL && PENABLE && !PREADY) |-> s_access_wait;
   endproperty
   a_one_wait: assert property (p_one_wait) else $error("ready not after one wait cycle");

   // completed read of any register
   sequence s_read_done;
      PSEL && PENABLE && PREADY && !PWRITE;
   endsequence

   // high word read returns the frozen word, never the live one
   property p_high_read;
      @(posedge REF_CLK) disable iff (RST)
      (PREADY && !PWRITE && sel == lpbps_pkg::LPBPS_SEL_HIGH) |-> PRDATA == {16'h0000, snap.high};
   endproperty
   a_high_read: assert property (p_high_read) else $error("high read not the snapshot");

   // low word is a live pass-through taken in the first access cycle
   property p_low_live;
      @(posedge REF_CLK) disable iff (RST)
      s_read_done ##0 (sel == lpbps_pkg::LPBPS_SEL_LOW) |-> PRDATA == {16'h0000, $past(PARTNER_PAGE[15:0])};
   endproperty
   a_low_live: assert property (p_low_live) else $error("low read not the live page");

   // registers are 16 bits wide, the upper half of the bus reads zero
   property p_upper_zero;
      @(posedge REF_CLK) disable iff (RST)
      PREADY |-> PRDATA[31:16] == 16'h0000;
   endproperty
   a_upper_zero: assert property (p_upper_zero) else $error("upper read data not zero");

   // unmapped or misaligned access answers with an error and zero data
   property p_err_unmapped;
      @(posedge REF_CLK) disable iff (RST)
      (PREADY && sel == lpbps_pkg::LPBPS_SEL_NONE) |-> PSLVERR && PRDATA == 32'h00000000;
   endproperty
   a_err_unmapped: assert property (p_err_unmapped) else $error("unmapped access not refused");

   // mapped registers answer okay, writes included
   property p_err_mapped;
      @(posedge REF_CLK) disable iff (RST)
      (PREADY && sel != lpbps_pkg::LPBPS_SEL_NONE) |-> !PSLVERR;
   endproperty
   a_err_mapped: assert property (p_err_mapped) else $error("mapped access got an error");

   // ready is a one-cycle pulse
   property p_ready_pulse;
      @(posedge REF_CLK) disable iff (RST)
      PREADY |=> !PREADY;
   endproperty
   a_ready_pulse: assert property (p_ready_pulse) else $error("ready held too long");

   // ready only ever answers an access phase
   property p_ready_in_access;
      @(posedge REF_CLK) disable iff (RST)
      PREADY |-> PSEL && PENABLE;
   endproperty
   a_ready_in_access: assert property (p_ready_in_access) else $error("ready outside access");

   // every output returns to zero after a reset cycle
   property p_reset_outputs;
      @(posedge REF_CLK)
      RST |=> !PREADY && !PSLVERR && PRDATA == 32'h00000000 && !TX_LEVEL_HIGH;
   endproperty
   a_reset_outputs: assert property (p_reset_outputs) else $error("outputs not cleared by reset");

   // low amplitude whenever either side lacks the ability
   property p_level_low;
      @(posedge REF_CLK) disable iff (RST)
      (!LOCAL_HIGH_AMPLITUDE_ABLE || !PARTNER_PAGE[32+`LPBPS_HIGH_HI_ABLE]) |=> !TX_LEVEL_HIGH;
   endproperty
   a_level_low: assert property (p_level_low) else $error("high level without both able");

   // both able and one side asking gives high amplitude
   property p_level_req;
      @(posedge REF_CLK) disable iff (RST)
      (LOCAL_HIGH_AMPLITUDE_ABLE && PARTNER_PAGE[32+`LPBPS_HIGH_HI_ABLE]
       && (LOCAL_HIGH_AMPLITUDE_REQUEST || PARTNER_PAGE[32+`LPBPS_HIGH_HI_REQ])) |=> TX_LEVEL_HIGH;
   endproperty
   a_level_req: assert property (p_level_req) else $error("high level not granted");

   // nobody asking keeps the low amplitude
   property p_level_none;
      @(posedge REF_CLK) disable iff (RST)
      (!LOCAL_HIGH_AMPLITUDE_REQUEST && !PARTNER_PAGE[32+`LPBPS_HIGH_HI_REQ]) |=> !TX_LEVEL_HIGH;
   endproperty
   a_level_none: assert property (p_level_none) else $error("high level without request");

   // master select lands at its own field position
   property p_master;
      @(posedge REF_CLK) disable iff (RST)
      s_low_read |=> snap.mid[`LPBPS_MID_MASTER] == $past(PARTNER_PAGE[16+`LPBPS_MID_MASTER]);
   endproperty
   a_master: assert property (p_master) else $error("master select misplaced");

   // the error flag drops once select is gone
   property p_err_clear;
      @(posedge REF_CLK) disable iff (RST)
      !PSEL |=> !PSLVERR;
   endproperty
   a_err_clear: assert property (p_err_clear) else $error("error flag outlived select");

   // read data only moves in an access phase
   property p_data_holds;
      @(posedge REF_CLK) disable iff (RST)
      !(PSEL && PENABLE) |=> $stable(PRDATA);
   endproperty
   a_data_holds: assert property (p_data_holds) else $error("read data moved while idle");

   // energy efficient ability lands at its own field position
   property p_eee;
      @(posedge REF_CLK) disable iff (RST)
      s_low_read |=> snap.high[`LPBPS_HIGH_EEE] == $past(PARTNER_PAGE[32+`LPBPS_HIGH_EEE]);
   endproperty
   a_eee: assert property (p_eee) else $error("energy efficient bit misplaced");

   // long reach ability lands at its own field position
   property p_long_reach;
      @(posedge REF_CLK) disable iff (RST)
      s_low_read |=> snap.mid[`LPBPS_MID_LONG_REACH] == $past(PARTNER_PAGE[16+`LPBPS_MID_LONG_REACH]);
   endproperty
   a_long_reach: assert property (p_long_reach) else $error("long reach bit misplaced");

   // the partner request feeds the level only, it reads zero in the word
   property p_req_hidden;
      @(posedge REF_CLK) disable iff (RST)
      snap.high[`LPBPS_HIGH_HI_REQ] == 1'b0;
   endproperty
   a_req_hidden: assert property (p_req_hidden) else $error("reserved request bit set");

   // high amplitude ability lands at its own field position
   property p_hi_able;
      @(posedge REF_CLK) disable iff (RST)
      s_low_read |=> snap.high[`LPBPS_HIGH_HI_ABLE] == $past(PARTNER_PAGE[32+`LPBPS_HIGH_HI_ABLE]);
   endproperty
   a_hi_able: assert property (p_hi_able) else $error("high amplitude bit misplaced");

   // no answer without a select
   property p_no_ready_idle;
      @(posedge REF_CLK) disable iff (RST)
      !PSEL |=> !PREADY;
   endproperty
   a_no_ready_idle: assert property (p_no_ready_idle) else $error("ready while idle");

endmodule : lpbps_snapshot

// ---- lpbps_params.svh ----
// Purpose: offsets, field positions and reset values of the partner base page snapshot
// Assumes: register offsets are word indices; byte address is four times the index
// Notes:   definitions only
`ifndef LPBPS_PARAMS_SVH
`define LPBPS_PARAMS_SVH

// register indices
`define LPBPS_IDX_LOW_WORD      12'h205
`define LPBPS_IDX_MID_WORD      12'h206
`define LPBPS_IDX_HIGH_WORD     12'h207

// reset value of both snapshot words
`define LPBPS_WORD_RESET        16'h0000

// middle word fields
`define LPBPS_MID_LONG_REACH    14
`define LPBPS_MID_GIGABIT       7
`define LPBPS_MID_SHORT_FD      6
`define LPBPS_MID_FAST          5
`define LPBPS_MID_MASTER        4
`define LPBPS_MID_MASK          16'h40F0

// high word fields
`define LPBPS_HIGH_EEE          14
`define LPBPS_HIGH_HI_ABLE      13
`define LPBPS_HIGH_HI_REQ       12
`define LPBPS_HIGH_SHORT_HD     11
`define LPBPS_HIGH_MASK         16'h6800

`endif

// ---- lpbps_pkg.sv ----
// Purpose: types of the partner base page snapshot
// Assumes: nothing beyond the params header
// Notes:   snapshot travels as one packed struct
package lpbps_pkg;

   // frozen middle and high words
   typedef struct packed {
      logic [15:0] mid;
      logic [15:0] high;
   } lpbps_snap_s;

   // which register an address selects
   typedef enum logic [1:0] {
      LPBPS_SEL_NONE,
      LPBPS_SEL_LOW,
      LPBPS_SEL_MID,
      LPBPS_SEL_HIGH
   } lpbps_sel_e;

endpackage : lpbps_pkg

// ---- lpbps_partner.sv ----
// Purpose: far-side model that presents the received partner base page
// Assumes: the bench commands each new page with a one-cycle load strobe
// Notes:   page is held as a level, the way a finished base page would be held
`timescale 1ns/1ps

module lpbps_partner (
   input  wire logic        ref_clk,
   input  wire logic        rst,
   input  wire logic        load,
   input  wire logic [47:0] new_page,
   output logic      [47:0] page
);
   // a new page may land at any time, also between low and mid reads
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         page <= 48'h000000000000;
      end else if (load) begin
         page <= new_page;
      end
   end
endmodule : lpbps_partner

// ---- testbench.sv ----
// Purpose: self-checking bench for the partner base page snapshot
// Assumes: APB master waits for PREADY; byte address is four times the index
// Notes:   pages use an all-ones pattern and sparse field patterns so a swapped field shows
`timescale 1ns/1ps
`include "lpbps_params.svh"

module testbench;
   logic        ref_clk = 1'b0;
   logic        rst = 1'b1;
   logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0, load = 1'b0;
   logic        loc_able = 1'b0, loc_req = 1'b0, err, pready, pslverr, tx_high;
   logic [13:0] paddr = 14'h0000;
   logic [31:0] pwdata = 32'hFFFFFFFF, prdata, rd;
   logic [47:0] new_page = 48'h000000000000, page;
   int          miscompares = 0, num_checks = 0;

   always #5 ref_clk = ~ref_clk;

   lpbps_partner partner (.ref_clk(ref_clk), .rst(rst), .load(load), .new_page(new_page), .page(page));

   lpbps_snapshot dut (.REF_CLK(ref_clk), .RST(rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
      .PADDR(paddr), .PWDATA(pwdata), .PREADY(pready), .PRDATA(prdata), .PSLVERR(pslverr),
      .PARTNER_PAGE(page), .LOCAL_HIGH_AMPLITUDE_ABLE(loc_able),
      .LOCAL_HIGH_AMPLITUDE_REQUEST(loc_req), .TX_LEVEL_HIGH(tx_high));

   task automatic close_out;
      $display("checks %0d mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : close_out

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   // one transfer; an idle cycle after it keeps psel from being assigned twice
   task automatic apb(input logic wr, input logic [11:0] idx);
      int n;
      n = 0;
      psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= {idx, 2'b00};
      @(posedge ref_clk);
      penable <= 1'b1;
      do begin
         @(posedge ref_clk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (pready !== 1'b1) miscompares++;
      rd = prdata;
      err = pslverr;
      psel <= 1'b0; penable <= 1'b0;
      @(posedge ref_clk);
   endtask : apb

   task automatic rd_chk(input logic [11:0] idx, input logic [31:0] exp);
      apb(1'b0, idx);
      chk(rd, exp);
      chk({31'h00000000, err}, 32'h00000000);
   endtask : rd_chk

   task automatic set_page(input logic [47:0] p);
      new_page <= p; load <= 1'b1;
      @(posedge ref_clk);
      load <= 1'b0;
      @(posedge ref_clk);
   endtask : set_page

   initial begin
      #200000;
      miscompares++;
      close_out();
   end

   initial begin
      repeat (2) @(posedge ref_clk);
      rst <= 1'b0;
      @(posedge ref_clk);
      rd_chk(`LPBPS_IDX_MID_WORD, 32'h00000000);
      rd_chk(`LPBPS_IDX_HIGH_WORD, 32'h00000000);
      $display("test reset done");
      set_page(48'hFFFFFFFFA5C3);
      rd_chk(`LPBPS_IDX_MID_WORD, 32'h00000000);
      rd_chk(`LPBPS_IDX_LOW_WORD, 32'h0000A5C3);
      rd_chk(`LPBPS_IDX_MID_WORD, 32'h000040F0);
      rd_chk(`LPBPS_IDX_HIGH_WORD, 32'h00006800);
      // newer page must stay hidden, writes must bounce off
      set_page(48'h200000900000);
      apb(1'b1, `LPBPS_IDX_MID_WORD);
      chk({31'h00000000, err}, 32'h00000000);
      apb(1'b1, `LPBPS_IDX_HIGH_WORD);
      rd_chk(`LPBPS_IDX_MID_WORD, 32'h000040F0);
      rd_chk(`LPBPS_IDX_HIGH_WORD, 32'h00006800);
      rd_chk(`LPBPS_IDX_LOW_WORD, 32'h00000000);
      rd_chk(`LPBPS_IDX_MID_WORD, 32'h00000090);
      rd_chk(`LPBPS_IDX_HIGH_WORD, 32'h00002000);
      set_page(48'h480040600000);
      rd_chk(`LPBPS_IDX_LOW_WORD, 32'h00000000);
      rd_chk(`LPBPS_IDX_MID_WORD, 32'h00004060);
      rd_chk(`LPBPS_IDX_HIGH_WORD, 32'h00004800);
      $display("test snapshot done");
      apb(1'b0, 12'h210);
      chk({31'h00000000, err}, 32'h00000001);
      chk(rd, 32'h00000000);
      $display("test unmapped done");
      // every combination of local and partner able/request bits
      for (int i = 0; i < 16; i++) begin
         loc_able <= i[0];
         loc_req <= i[1];
         set_page({2'b00, i[2], i[3], 44'h00000000000});
         @(posedge ref_clk);
         chk({31'h00000000, tx_high}, {31'h00000000, i[0] & i[2] & (i[1] | i[3])});
      end
      $display("test level done");
      close_out();
   end
endmodule : testbench
